// ==== config_word_and_program_entry_asserts.sv ====
// Purpose: Checks the serial link between the programmer and device ends.
// Assumes: Link clock half period of eight system clocks.
// Notes:   Watches the interface signals only.
`timescale 1ns/1ns
module config_word_and_program_entry_asserts (
    input wire logic clk,
    input wire logic rstn,
    input wire logic progClockPin,
    input wire logic masterClearHigh,
    input wire logic hostData,
    input wire logic hostDataOe,
    input wire logic devData,
    input wire logic devDataOe,
    input wire logic progDataPin
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////
    property p_entry_low;
        $rose(masterClearHigh) |-> !progDataPin && !progClockPin
            ##1 !progClockPin[*7];
    endproperty
    a_entry_low: assert property (p_entry_low)
        else $error("link not quiet at mode entry");
    property p_clock_idle;
        !masterClearHigh |-> !progClockPin;
    endproperty
    a_clock_idle: assert property (p_clock_idle)
        else $error("link clock runs outside mode");
    property p_one_driver;
        !(hostDataOe && devDataOe);
    endproperty
    a_one_driver: assert property (p_one_driver)
        else $error("both ends drive the data line");
    property p_clock_high;
        $rose(progClockPin) |-> progClockPin[*8] ##1 !progClockPin;
    endproperty
    a_clock_high: assert property (p_clock_high)
        else $error("link clock high phase wrong");
    property p_clock_low;
        $fell(progClockPin) |-> !progClockPin[*8];
    endproperty
    a_clock_low: assert property (p_clock_low)
        else $error("link clock low phase too short");
    property p_host_hold;
        progClockPin && $past(progClockPin) && hostDataOe && $past(hostDataOe)
            |-> $stable(hostData);
    endproperty
    a_host_hold: assert property (p_host_hold)
        else $error("host data moved while clock high");
    property p_dev_in_mode;
        devDataOe |-> masterClearHigh;
    endproperty
    a_dev_in_mode: assert property (p_dev_in_mode)
        else $error("device drives data outside mode");
    property p_dev_bit;
        devDataOe && $fell(progClockPin) |-> devData == $past(devData, 3);
    endproperty
    a_dev_bit: assert property (p_dev_bit)
        else $error("device data bit not settled at fall");
    c_entry: cover property ($rose(masterClearHigh));
    c_read: cover property ($rose(devDataOe));
    c_exit: cover property ($fell(masterClearHigh));
endmodule

// ==== config_word_and_program_entry_tb.sv ====
// Purpose: Drives programmer and device ends joined by the link.
// Assumes: Writes can only clear bits of erased cells.
// Notes:   Read words are checked by a monitor from a queue.
`timescale 1ns/1ns
module config_word_and_program_entry_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic enterProg = 1'b0;
    logic cmdValid = 1'b0;
    logic rdReady = 1'b0;
    logic [5:0] cmdCode = 6'h00;
    logic [13:0] cmdData = 14'h0000;
    logic [8:0] fetchAddr = 9'h000;
    logic cmdReady, rdValid, linkActive, progMode, boEn, ptEn, wdEn, lowProt;
    logic [13:0] rdData, fetchWord, w;
    logic [1:0] oscSel, cpPair;
    logic [13:0] expQ[$];
    int badCount = 0;
    int nTests = 0;
    always #5 clk = ~clk;
    prog_link_if link();
    serial_programmer u_serial_programmer (.clk, .rstn, .ce(1'b1),
        .link(link), .enterProg, .cmdValid, .cmdReady, .cmdCode, .cmdData,
        .rdValid, .rdReady, .rdData, .linkActive);
    config_word_device u_config_word_device (.clk, .rstn, .ce(1'b1),
        .link(link), .fetchAddr, .fetchWord, .progMode,
        .brownoutResetEnable(boEn), .powerupTimerEnable(ptEn),
        .watchdogEnable(wdEn), .oscillatorSelect(oscSel),
        .codeProtectPair(cpPair), .lowBlockProtected(lowProt));
    config_word_and_program_entry_asserts u_asserts (.clk, .rstn,
        .progClockPin(link.progClockPin),
        .masterClearHigh(link.masterClearHigh), .hostData(link.hostData),
        .hostDataOe(link.hostDataOe), .devData(link.devData),
        .devDataOe(link.devDataOe), .progDataPin(link.progDataPin));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        nTests++;
        if (seen !== exp) begin
            badCount++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic finalReport();
        if (badCount == 0 && nTests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cmd(input logic [5:0] c, input logic [13:0] d,
                       input logic rd, input logic [13:0] e);
        int n;
        n = 0;
        cmdCode <= c;
        cmdData <= d;
        cmdValid <= 1'b1;
        if (rd) begin
            expQ.push_back(e);
        end
        do @(negedge clk); while (cmdReady !== 1'b1 && ++n < 2000);
        if (n >= 2000) badCount++;
        @(posedge clk);
        cmdValid <= 1'b0;
        @(posedge clk);
    endtask
    task automatic mode(input logic on);
        int n;
        n = 0;
        do @(negedge clk);
        while (!on && (cmdReady !== 1'b1 || expQ.size() > 0) && ++n < 4000);
        @(posedge clk);
        enterProg <= on;
        n = 0;
        do @(negedge clk); while (progMode !== on && ++n < 200);
        check({13'h0000, progMode}, {13'h0000, on});
        n = 0;
        do @(negedge clk); while (linkActive !== on && ++n < 200);
        check({13'h0000, linkActive}, {13'h0000, on});
        @(posedge clk);
    endtask
    task automatic cfg(input logic [7:0] e);
        check({6'h00, boEn, ptEn, wdEn, oscSel, cpPair, lowProt},
              {6'h00, e});
    endtask
    // The monitor pops one note for every word the buffer hands over.
    always @(negedge clk) begin
        if (rdValid === 1'b1 && rdReady === 1'b1) begin
            check(rdData, expQ.size() > 0 ? expQ.pop_front() : ~rdData);
        end
    end
    always @(posedge clk) begin
        rdReady <= 1'($urandom());
    end
    initial begin
        #600000;
        badCount++;
        finalReport();
    end
    initial begin
        void'($urandom(46058));
        w = 14'($urandom());
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        cfg(8'hfe);
        check(fetchWord, prog_pkg::ERASED_WORD);
        mode(1'b1);
        cmd(prog_pkg::CMD_READ_DATA, 14'h0000, 1'b1, prog_pkg::ERASED_WORD);
        cmd(prog_pkg::CMD_LOAD_DATA, w, 1'b0, 14'h0000);
        cmd(prog_pkg::CMD_READ_DATA, 14'h0000, 1'b1, w);
        cmd(prog_pkg::CMD_INC_ADDR, 14'h0000, 1'b0, 14'h0000);
        cmd(prog_pkg::CMD_READ_DATA, 14'h0000, 1'b1, prog_pkg::ERASED_WORD);
        cmd(prog_pkg::CMD_LOAD_CONFIG, w, 1'b0, 14'h0000);
        cmd(prog_pkg::CMD_READ_DATA, 14'h0000, 1'b1, {10'h000, w[3:0]});
        repeat (7) cmd(prog_pkg::CMD_INC_ADDR, 14'h0000, 1'b0, 14'h0000);
        cmd(prog_pkg::CMD_LOAD_DATA, 14'h0002, 1'b0, 14'h0000);
        cmd(prog_pkg::CMD_READ_DATA, 14'h0000, 1'b1, 14'h0082);
        mode(1'b0);
        cfg(8'h51);
        check(fetchWord, w);
        mode(1'b1);
        cmd(prog_pkg::CMD_READ_DATA, 14'h0000, 1'b1, 14'h0000);
        mode(1'b0);
        finalReport();
    end
endmodule

// ==== config_word_device.sv ====
// Purpose: Device end: configuration word decode, ID locations, program
//          memory and the serial program/verify command engine.
// Assumes: Link pins arrive asynchronously and are synchronised here.
// Notes:   Programming can only clear bits; erased cells read as ones.
`timescale 1ns/1ns
module config_word_device #(
    parameter int MEM_DEPTH = 512,
    parameter int AW = $clog2(MEM_DEPTH)
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    prog_link_if.device link,
    input wire logic [AW-1:0] fetchAddr,
    output logic [prog_pkg::WORD_W-1:0] fetchWord,
    output logic progMode,
    output logic brownoutResetEnable,
    output logic powerupTimerEnable,
    output logic watchdogEnable,
    output logic [1:0] oscillatorSelect,
    output logic [1:0] codeProtectPair,
    output logic lowBlockProtected
);
    localparam int W = prog_pkg::WORD_W;
    localparam int CW = prog_pkg::CMD_W;
    localparam int PIN_CLK = 0;
    localparam int PIN_DATA = 1;
    localparam int PIN_MASTER_CLEAR_PIN = 2;

    generate
        if (MEM_DEPTH < 2 || MEM_DEPTH > 8192
            || MEM_DEPTH != (1 << AW)) begin : g_bad
            $error("MEM_DEPTH must be a power of two up to 8192");
        end
    endgenerate

    typedef enum logic [1:0] {OFF, CMD, LOADW, READW} state_type;

    state_type state_q;
    logic [2:0] pinMeta_q;
    logic [2:0] pinSync_q;
    logic [2:0] pinPrev_q;
    logic clkRise;
    logic clkFall;
    logic mclrRise;
    logic [3:0] bitCnt_q;
    logic [CW-1:0] cmd_q;
    logic [CW-1:0] cmdNext;
    logic [W-1:0] shift_q;
    logic [W-1:0] wordNext;
    logic [prog_pkg::ADDR_W-1:0] pc_q;
    logic [W-1:0] progMem_q [MEM_DEPTH];
    logic [prog_pkg::ID_W-1:0] idMem_q [prog_pkg::ID_COUNT];
    logic [W-1:0] cfg_q;
    logic [W-1:0] readValue;
    logic wrEn;
    logic inUser;
    logic inIds;
    logic protectHit;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection on the second stage.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pinMeta_q <= 3'h0;
            pinSync_q <= 3'h0;
            pinPrev_q <= 3'h0;
        end else if (ce) begin
            pinMeta_q <= {link.masterClearHigh, link.progDataPin,
                          link.progClockPin};
            pinSync_q <= pinMeta_q;
            pinPrev_q <= pinSync_q;
        end
    end

    assign clkRise = pinSync_q[PIN_CLK] && !pinPrev_q[PIN_CLK];
    assign clkFall = !pinSync_q[PIN_CLK] && pinPrev_q[PIN_CLK];
    assign mclrRise = pinSync_q[PIN_MASTER_CLEAR_PIN] && !pinPrev_q[PIN_MASTER_CLEAR_PIN];
    assign cmdNext = {pinSync_q[PIN_DATA], cmd_q[CW-1:1]};
    assign wordNext = {pinSync_q[PIN_DATA], shift_q[W-1:1]};
    assign progMode = state_q != OFF;

    ////////////////////////////////////////////////////////////////////////
    // Address decode for the verify path.
    assign inUser = (pc_q < prog_pkg::TEST_BASE)
                    && (pc_q < prog_pkg::ADDR_W'(MEM_DEPTH));
    assign inIds = (pc_q >= prog_pkg::ID_BASE)
                   && (pc_q <= prog_pkg::ID_LAST);
    assign protectHit = (codeProtectPair == prog_pkg::PAIR_PROTECT_LOW)
                        && (pc_q <= prog_pkg::PROTECT_LAST);

    always_comb begin
        readValue = '0;
        if (inUser && !protectHit) begin
            readValue = progMem_q[pc_q[AW-1:0]];
        end else if (inIds) begin
            readValue = {{(W - prog_pkg::ID_W){1'b0}},
                         idMem_q[pc_q[1:0]]};
        end else if (pc_q == prog_pkg::CFG_ADDR) begin
            readValue = cfg_q;
            readValue[prog_pkg::CFG_UNUSED_BIT] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial command engine.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= OFF;
            bitCnt_q <= 4'h0;
            cmd_q <= '0;
            shift_q <= '0;
            pc_q <= prog_pkg::PC_RESET;
            link.devData <= 1'b0;
            link.devDataOe <= 1'b0;
        end else if (ce) begin
            if (!pinSync_q[PIN_MASTER_CLEAR_PIN]) begin
                state_q <= OFF;
                link.devDataOe <= 1'b0;
            end else begin
                unique case (state_q)
                    OFF: begin
                        if (mclrRise && !pinSync_q[PIN_CLK]
                            && !pinSync_q[PIN_DATA]) begin
                            state_q <= CMD;
                            pc_q <= prog_pkg::PC_RESET;
                            bitCnt_q <= 4'h0;
                        end
                    end
                    CMD: begin
                        if (clkFall) begin
                            cmd_q <= cmdNext;
                            bitCnt_q <= bitCnt_q + 4'h1;
                            if (bitCnt_q == 4'(CW - 1)) begin
                                bitCnt_q <= 4'h0;
                                if (cmdNext == prog_pkg::CMD_LOAD_CONFIG) begin
                                    pc_q <= prog_pkg::TEST_BASE;
                                end
                                if (prog_pkg::cmdIsLoad(cmdNext)) begin
                                    state_q <= LOADW;
                                end else if (prog_pkg::cmdIsRead(cmdNext)) begin
                                    state_q <= READW;
                                    shift_q <= readValue;
                                end else if (cmdNext
                                             == prog_pkg::CMD_INC_ADDR) begin
                                    pc_q <= pc_q + 14'h0001;
                                end
                            end
                        end
                    end
                    LOADW: begin
                        if (clkFall) begin
                            shift_q <= wordNext;
                            bitCnt_q <= bitCnt_q + 4'h1;
                            if (bitCnt_q == 4'(W - 1)) begin
                                bitCnt_q <= 4'h0;
                                state_q <= CMD;
                            end
                        end
                    end
                    READW: begin
                        if (clkRise) begin
                            link.devDataOe <= 1'b1;
                            link.devData <= shift_q[0];
                            shift_q <= shift_q >> 1;
                        end
                        if (clkFall) begin
                            bitCnt_q <= bitCnt_q + 4'h1;
                            if (bitCnt_q == 4'(W - 1)) begin
                                bitCnt_q <= 4'h0;
                                link.devDataOe <= 1'b0;
                                state_q <= CMD;
                            end
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage. Only the serial engine writes, so test space stays
    // out of reach of normal execution.
    assign wrEn = ce && pinSync_q[PIN_MASTER_CLEAR_PIN] && (state_q == LOADW)
                  && clkFall && (bitCnt_q == 4'(W - 1));

    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                progMem_q[i] <= prog_pkg::ERASED_WORD;
            end
            for (int i = 0; i < prog_pkg::ID_COUNT; i++) begin
                idMem_q[i] <= prog_pkg::ERASED_ID;
            end
            cfg_q <= prog_pkg::ERASED_WORD;
        end else if (wrEn) begin
            if (inUser) begin
                progMem_q[pc_q[AW-1:0]] <= progMem_q[pc_q[AW-1:0]]
                                           & wordNext;
            end else if (inIds) begin
                idMem_q[pc_q[1:0]] <= idMem_q[pc_q[1:0]]
                    & wordNext[prog_pkg::ID_W-1:0];
            end else if (pc_q == prog_pkg::CFG_ADDR) begin
                cfg_q <= cfg_q & wordNext;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded settings and instruction fetch from user space only.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            brownoutResetEnable <= 1'b0;
            powerupTimerEnable <= 1'b0;
            watchdogEnable <= 1'b0;
            oscillatorSelect <= 2'h0;
            codeProtectPair <= 2'h3;
            lowBlockProtected <= 1'b0;
            fetchWord <= '0;
        end else if (ce) begin
            brownoutResetEnable <= cfg_q[prog_pkg::BROWNOUT_BIT];
            powerupTimerEnable <= !cfg_q[prog_pkg::POWERUP_N_BIT]
                || cfg_q[prog_pkg::BROWNOUT_BIT];
            watchdogEnable <= cfg_q[prog_pkg::WATCHDOG_BIT];
            oscillatorSelect <= cfg_q[prog_pkg::OSC_LSB+:2];
            codeProtectPair <= cfg_q[prog_pkg::PAIR_LSB+:2];
            lowBlockProtected <= cfg_q[prog_pkg::PAIR_LSB+:2]
                                 == prog_pkg::PAIR_PROTECT_LOW;
            fetchWord <= progMem_q[fetchAddr];
        end
    end
endmodule

// ==== prog_link_if.sv ====
// Purpose: Serial program link between programmer and device.
// Assumes: The data pin is two-way; the wire is resolved here.
// Notes:   An undriven data line floats high through a pull-up.
`timescale 1ns/1ns
interface prog_link_if;
    logic progClockPin;
    logic masterClearHigh;
    logic hostData;
    logic hostDataOe;
    logic devData;
    logic devDataOe;
    logic progDataPin;

    assign progDataPin = hostDataOe ? hostData :
                         (devDataOe ? devData : 1'b1);

    modport device(
        input progClockPin,
        input masterClearHigh,
        input progDataPin,
        output devData,
        output devDataOe
    );

    modport programmer(
        output progClockPin,
        output masterClearHigh,
        output hostData,
        output hostDataOe,
        input progDataPin
    );
endinterface

// ==== prog_pkg.sv ====
// Purpose: Shared constants for the configuration word and serial program
//          link between a device end and a programmer end.
// Assumes: 14-bit words, 6-bit commands, data shifted LSB first.
// Notes:   Command codes and entry timing are local choices.
package prog_pkg;

    localparam int WORD_W = 14;
    localparam int CMD_W = 6;
    localparam int ADDR_W = 14;
    localparam int ID_W = 4;
    localparam int ID_COUNT = 4;

    localparam logic [ADDR_W-1:0] PC_RESET = 14'h0000;
    localparam logic [ADDR_W-1:0] TEST_BASE = 14'h2000;
    localparam logic [ADDR_W-1:0] ID_BASE = 14'h2000;
    localparam logic [ADDR_W-1:0] ID_LAST = 14'h2003;
    localparam logic [ADDR_W-1:0] CFG_ADDR = 14'h2007;
    localparam logic [ADDR_W-1:0] PROTECT_LAST = 14'h01ff;
    localparam logic [WORD_W-1:0] ERASED_WORD = 14'h3fff;
    localparam logic [ID_W-1:0] ERASED_ID = 4'hf;

    // Configuration word field positions.
    localparam int CFG_UNUSED_BIT = 7;
    localparam int BROWNOUT_BIT = 6;
    localparam int POWERUP_N_BIT = 3;
    localparam int WATCHDOG_BIT = 2;
    localparam int OSC_LSB = 0;
    localparam int PAIR_LSB = 4;

    localparam logic [1:0] OSC_RC = 2'h3;
    localparam logic [1:0] OSC_FAST_CRYSTAL = 2'h2;
    localparam logic [1:0] OSC_CRYSTAL = 2'h1;
    localparam logic [1:0] PAIR_PROTECT_LOW = 2'h0;

    localparam logic [CMD_W-1:0] CMD_LOAD_CONFIG = 6'h00;
    localparam logic [CMD_W-1:0] CMD_LOAD_DATA = 6'h02;
    localparam logic [CMD_W-1:0] CMD_READ_DATA = 6'h04;
    localparam logic [CMD_W-1:0] CMD_INC_ADDR = 6'h06;

    localparam int CLK_NS = 10;
    localparam int ENTRY_NS = 100;
    localparam int ENTRY_CYC = (ENTRY_NS + CLK_NS - 1) / CLK_NS;

    function automatic logic cmdIsLoad(input logic [CMD_W-1:0] c);
        return (c == CMD_LOAD_CONFIG) || (c == CMD_LOAD_DATA);
    endfunction

    function automatic logic cmdIsRead(input logic [CMD_W-1:0] c);
        return c == CMD_READ_DATA;
    endfunction

endpackage

// ==== serial_programmer.sv ====
// Purpose: Programmer end: enters program/verify mode and runs commands.
// Assumes: clk at 100 MHz; link clock made here by a divider.
// Notes:   Read words pass a two-entry buffer to the user side.
`timescale 1ns/1ns
module serial_programmer #(
    parameter int HALF_DIV = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    prog_link_if.programmer link,
    input wire logic enterProg,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic [prog_pkg::CMD_W-1:0] cmdCode,
    input wire logic [prog_pkg::WORD_W-1:0] cmdData,
    output logic rdValid,
    input wire logic rdReady,
    output logic [prog_pkg::WORD_W-1:0] rdData,
    output logic linkActive
);
    localparam int TOTAL = prog_pkg::CMD_W + prog_pkg::WORD_W;

    generate
        if (HALF_DIV < 8 || HALF_DIV > 255) begin : g_bad
            $error("HALF_DIV must lie in 8..255");
        end
    endgenerate

    typedef enum logic [2:0] {OFF, SETUP, RAISE, IDLE, SHIFT} state_type;

    state_type state_q;
    logic [7:0] div_q;
    logic [4:0] bit_q;
    logic [4:0] last_q;
    logic isRead_q;
    logic [TOTAL-1:0] sh_q;
    logic [prog_pkg::WORD_W-1:0] rdShift_q;
    logic dataMeta_q;
    logic dataSync_q;
    logic push;
    logic pop;
    logic [prog_pkg::WORD_W-1:0] pushWord;
    logic [prog_pkg::WORD_W-1:0] buf_q [2];
    logic wrPtr_q;
    logic rdPtr_q;
    logic [1:0] count_q;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!rstn) begin
            dataMeta_q <= 1'b1;
            dataSync_q <= 1'b1;
        end else if (ce) begin
            dataMeta_q <= link.progDataPin;
            dataSync_q <= dataMeta_q;
        end
    end

    // Room for a read word is kept before a command is taken.
    assign cmdReady = (state_q == IDLE) && (count_q < 2'h2);
    assign linkActive = (state_q == IDLE) || (state_q == SHIFT);
    // The last data bit was shifted in at mid-bit, so the word is whole.
    assign pushWord = rdShift_q;
    assign push = ce && (state_q == SHIFT) && isRead_q
                  && (bit_q == last_q) && (div_q == 8'(2 * HALF_DIV - 1));

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= OFF;
            div_q <= '0;
            bit_q <= '0;
            last_q <= '0;
            isRead_q <= 1'b0;
            sh_q <= '0;
            rdShift_q <= '0;
            link.progClockPin <= 1'b0;
            link.masterClearHigh <= 1'b0;
            link.hostData <= 1'b0;
            link.hostDataOe <= 1'b0;
        end else if (ce) begin
            unique case (state_q)
                OFF: begin
                    link.masterClearHigh <= 1'b0;
                    link.hostDataOe <= 1'b0;
                    if (enterProg) begin
                        state_q <= SETUP;
                        div_q <= '0;
                    end
                end
                SETUP: begin
                    link.progClockPin <= 1'b0;
                    link.hostData <= 1'b0;
                    link.hostDataOe <= 1'b1;
                    div_q <= div_q + 8'h01;
                    if (div_q == 8'(prog_pkg::ENTRY_CYC)) begin
                        link.masterClearHigh <= 1'b1;
                        state_q <= RAISE;
                        div_q <= '0;
                    end
                end
                RAISE: begin
                    div_q <= div_q + 8'h01;
                    if (div_q == 8'(prog_pkg::ENTRY_CYC)) begin
                        state_q <= IDLE;
                    end
                end
                IDLE: begin
                    link.progClockPin <= 1'b0;
                    link.hostData <= 1'b0;
                    link.hostDataOe <= 1'b1;
                    div_q <= '0;
                    bit_q <= '0;
                    if (!enterProg) begin
                        state_q <= OFF;
                    end else if (cmdValid && cmdReady) begin
                        state_q <= SHIFT;
                        sh_q <= {cmdData, cmdCode};
                        isRead_q <= prog_pkg::cmdIsRead(cmdCode);
                        last_q <= (prog_pkg::cmdIsLoad(cmdCode)
                                   || prog_pkg::cmdIsRead(cmdCode))
                                  ? 5'(TOTAL - 1)
                                  : 5'(prog_pkg::CMD_W - 1);
                    end
                end
                SHIFT: begin
                    div_q <= div_q + 8'h01;
                    if (div_q == 8'h00) begin
                        link.progClockPin <= 1'b1;
                        link.hostData <= sh_q[0];
                        link.hostDataOe <= !(isRead_q
                            && bit_q >= 5'(prog_pkg::CMD_W));
                    end
                    if (div_q == 8'(HALF_DIV - 1) && isRead_q
                        && bit_q >= 5'(prog_pkg::CMD_W)) begin
                        rdShift_q <= {dataSync_q,
                            rdShift_q[prog_pkg::WORD_W-1:1]};
                    end
                    if (div_q == 8'(HALF_DIV)) begin
                        link.progClockPin <= 1'b0;
                    end
                    if (div_q == 8'(2 * HALF_DIV - 1)) begin
                        div_q <= '0;
                        sh_q <= sh_q >> 1;
                        bit_q <= bit_q + 5'h01;
                        if (bit_q == last_q) begin
                            state_q <= IDLE;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-entry buffer between the link and the user read port.
    assign rdValid = count_q != 2'h0;
    assign rdData = buf_q[rdPtr_q];
    assign pop = ce && rdValid && rdReady;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wrPtr_q <= 1'b0;
            rdPtr_q <= 1'b0;
            count_q <= 2'h0;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end else begin
            if (push) begin
                buf_q[wrPtr_q] <= pushWord;
                wrPtr_q <= !wrPtr_q;
            end
            if (pop) begin
                rdPtr_q <= !rdPtr_q;
            end
            if (push && !pop) begin
                count_q <= count_q + 2'h1;
            end else if (pop && !push) begin
                count_q <= count_q - 2'h1;
            end
        end
    end
endmodule
